//--- hw/dwd_pkg.sv
package dwd_pkg;
	localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hD8;
	localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'hFE;
	localparam int ACTIVATE_BIT = 0;
	localparam int SOFT_RESET_BIT = 1;
	localparam int PERIOD_TOP = 2;
	localparam int PERIOD_LSB = 7;
	localparam int TICK_CYCLES = 3072;
	localparam logic [11:0] TICK_LAST = 12'hBFF;
	localparam int STAB_CYCLES = 64;
	localparam logic [6:0] STAB_LAST = 7'h3F;

	typedef struct packed {
		logic wrEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} dwd_bus_t;
endpackage

//--- hw/dwd_watchdog.sv
`timescale 1ns/1ps
module dwd_watchdog (
	input wire logic core_clk,
	input wire logic reset,
	input wire dwd_pkg::dwd_bus_t bus,
	output logic [7:0] rdData,
	input wire logic hwActivation,
	input wire logic extStopControl,
	input wire logic nmiPin,
	input wire logic stopRequest,
	input wire logic wakeEvent,
	output logic stopMode,
	output logic waitMode,
	output logic oscRun,
	output logic deviceReset
);
	logic [6:0] count_q;
	logic active_q;
	logic frozen_q;
	logic [11:0] tick_q;
	logic tickPulse;
	logic wdWrite;
	logic [6:0] wrCount;
	logic expire;
	logic wdReset;
	logic [6:0] stab_q;
	logic stabBusy_q;
	logic isActive;

	assign wdWrite = bus.wrEn && (bus.addr == dwd_pkg::WATCHDOG_CONTROL_ADDR) && !stabBusy_q;
	// reversed period mapping
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : gMap
			assign wrCount[gi] = bus.wrData[dwd_pkg::PERIOD_LSB - gi];
			assign rdData[dwd_pkg::PERIOD_LSB - gi] = count_q[gi];
		end
	endgenerate
	assign wrCount[6] = bus.wrData[dwd_pkg::SOFT_RESET_BIT];
	assign rdData[dwd_pkg::SOFT_RESET_BIT] = count_q[6];
	assign isActive = hwActivation | active_q;
	assign rdData[dwd_pkg::ACTIVATE_BIT] = isActive;

	assign tickPulse = (tick_q == dwd_pkg::TICK_LAST) && !frozen_q && !stabBusy_q;

	// cycle divider, restarted by a write
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			tick_q <= '0;
		else if (wdWrite || stabBusy_q)
			tick_q <= '0;
		else if (!frozen_q)
			tick_q <= (tick_q == dwd_pkg::TICK_LAST) ? 12'h000 : tick_q + 12'h001;
	end

	assign expire = isActive && tickPulse && (count_q[6]) && (count_q[5:0] == 6'h00);
	assign wdReset = isActive && (expire || (wdWrite && !bus.wrData[dwd_pkg::SOFT_RESET_BIT]));

	// counter
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			count_q <= 7'h7F;
		else if (wdReset || stabBusy_q)
			count_q <= 7'h7F;
		else if (wdWrite)
			count_q <= wrCount;
		else if (tickPulse)
			count_q <= count_q - 7'h01;
	end

	// activation latch
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			active_q <= 1'b0;
		else if (wdReset || stabBusy_q)
			active_q <= 1'b0;
		else if (wdWrite && bus.wrData[dwd_pkg::ACTIVATE_BIT])
			active_q <= 1'b1;
	end

	// stabilisation delay after a watchdog reset
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			stabBusy_q <= 1'b0;
			stab_q <= '0;
		end
		else if (wdReset)
		begin
			stabBusy_q <= 1'b1;
			stab_q <= '0;
		end
		else if (stabBusy_q)
		begin
			stab_q <= stab_q + 7'h01;
			if (stab_q == dwd_pkg::STAB_LAST)
				stabBusy_q <= 1'b0;
		end
	end
	assign deviceReset = stabBusy_q;

	// stop and wait handling
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			frozen_q <= 1'b0;
			waitMode <= 1'b0;
		end
		else if (stabBusy_q || wakeEvent)
		begin
			frozen_q <= 1'b0;
			waitMode <= 1'b0;
		end
		else if (stopRequest && !frozen_q && !waitMode)
		begin
			if (!isActive)
				frozen_q <= 1'b1;
			else if (extStopControl && nmiPin)
				frozen_q <= 1'b1;
			else
				waitMode <= 1'b1;
		end
	end
	assign stopMode = frozen_q;
	assign oscRun = !frozen_q;

	// helper: cycles the current device reset has stood
	logic [7:0] stabLen_q;
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			stabLen_q <= 8'h00;
		else if (!deviceReset)
			stabLen_q <= 8'h00;
		else if (stabLen_q != 8'hFF)
			stabLen_q <= stabLen_q + 8'h01;
	end

	AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (reset)
		wdWrite && isActive && !bus.wrData[dwd_pkg::SOFT_RESET_BIT] && !stabBusy_q |=> deviceReset)
		else $error("soft reset bit clear did not reset");
	AST_EXPIRE: assert property (@(posedge core_clk) disable iff (reset)
		expire && !wdWrite |=> deviceReset && count_q == 7'h7F)
		else $error("expiry did not reset");
	AST_NO_RESET_INACTIVE: assert property (@(posedge core_clk) disable iff (reset)
		!isActive && !stabBusy_q |=> !deviceReset)
		else $error("inactive watchdog reset device");
	AST_STICKY: assert property (@(posedge core_clk) disable iff (reset)
		active_q && !wdReset && !stabBusy_q |=> active_q)
		else $error("activation cleared");
	AST_SW_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		!active_q && !(wdWrite && bus.wrData[dwd_pkg::ACTIVATE_BIT]) |=> !active_q)
		else $error("activation set without write");
	AST_HW_READ: assert property (@(posedge core_clk) disable iff (reset)
		hwActivation |-> rdData[dwd_pkg::ACTIVATE_BIT])
		else $error("activation bit not one");
	AST_FREEZE: assert property (@(posedge core_clk) disable iff (reset)
		frozen_q && !wakeEvent && !stabBusy_q |=> $stable(count_q))
		else $error("frozen counter moved");
	AST_STOP_INACTIVE: assert property (@(posedge core_clk) disable iff (reset)
		stopRequest && !isActive && !stopMode && !waitMode && !stabBusy_q && !wakeEvent
		|=> stopMode && !oscRun)
		else $error("inactive stop did not halt");
	AST_HW_WAIT: assert property (@(posedge core_clk) disable iff (reset)
		stopRequest && hwActivation && !extStopControl && !stopMode && !waitMode
		&& !stabBusy_q && !wakeEvent |=> waitMode && oscRun)
		else $error("hardware stop not taken as wait");
	AST_WAIT: assert property (@(posedge core_clk) disable iff (reset)
		stopRequest && !stopMode && !waitMode && isActive && !stabBusy_q && !wakeEvent
		&& !(extStopControl && nmiPin) |=> waitMode && oscRun)
		else $error("stop not taken as wait");
	AST_NMI_STOP: assert property (@(posedge core_clk) disable iff (reset)
		stopRequest && isActive && extStopControl && nmiPin && !stopMode && !waitMode
		&& !stabBusy_q && !wakeEvent |=> stopMode && !oscRun)
		else $error("stop with nmi high not taken");
	AST_WAKE: assert property (@(posedge core_clk) disable iff (reset)
		wakeEvent |=> !stopMode && !waitMode)
		else $error("wake did not leave low power");
	AST_DEC_STEP: assert property (@(posedge core_clk) disable iff (reset)
		tickPulse && !wdWrite && !wdReset |=> count_q == $past(count_q) - 7'h01)
		else $error("counter did not step down");
	AST_NO_EARLY_DEC: assert property (@(posedge core_clk) disable iff (reset)
		!tickPulse && !wdWrite && !wdReset && !stabBusy_q |=> $stable(count_q))
		else $error("counter moved between ticks");
	AST_RELOAD: assert property (@(posedge core_clk) disable iff (reset)
		wdWrite && !wdReset && !stabBusy_q |=> count_q == $past(wrCount) && tick_q == 12'h000)
		else $error("write did not restart");
	AST_STAB: assert property (@(posedge core_clk) disable iff (reset)
		$rose(deviceReset) |-> deviceReset [*8])
		else $error("reset too short");
	AST_STAB_LEN: assert property (@(posedge core_clk) disable iff (reset)
		$fell(deviceReset) |-> int'(stabLen_q) == dwd_pkg::STAB_CYCLES)
		else $error("device reset length wrong");
	AST_REINIT: assert property (@(posedge core_clk) disable iff (reset)
		$fell(deviceReset) |-> count_q == 7'h7F && !active_q)
		else $error("counter not reinitialised");
	COV_EXPIRE: cover property (@(posedge core_clk) expire);
	COV_STOP: cover property (@(posedge core_clk) $rose(stopMode));
	COV_WAIT: cover property (@(posedge core_clk) $rose(waitMode));
	COV_SOFT_RESET: cover property (@(posedge core_clk) wdWrite && isActive && !bus.wrData[1]);
	COV_RELOAD: cover property (@(posedge core_clk) wdWrite && isActive && bus.wrData[1]);
endmodule

//--- verification/tb_digital_watchdog_downcounter.sv
`timescale 1ns/1ps
module tb_digital_watchdog_downcounter;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	dwd_pkg::dwd_bus_t bus = '0;
	logic hwActivation = 1'b0;
	logic extStopControl = 1'b0;
	logic nmiPin = 1'b0;
	logic stopRequest = 1'b0;
	logic wakeEvent = 1'b0;
	logic [7:0] rdData;
	logic stopMode, waitMode, oscRun, deviceReset;
	int mismatches = 0;
	int compares = 0;
	logic [7:0] v;
	logic [8:0] e;
	logic [8:0] expQ[$];
	always #4 core_clk = ~core_clk;
	dwd_watchdog i_dwd_watchdog (.core_clk(core_clk), .reset(reset), .bus(bus),
		.rdData(rdData), .hwActivation(hwActivation), .extStopControl(extStopControl),
		.nmiPin(nmiPin), .stopRequest(stopRequest), .wakeEvent(wakeEvent),
		.stopMode(stopMode), .waitMode(waitMode), .oscRun(oscRun), .deviceReset(deviceReset));
	task automatic give_verdict();
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp_reg(input logic [7:0] x);
		compares++;
		if (rdData !== x)
			$display("Error rdData expected %h seen %h", x, rdData);
		if (rdData !== x)
			mismatches++;
	endtask
	task automatic cmp_stat(input logic [3:0] x);
		compares++;
		if ({stopMode, waitMode, oscRun, deviceReset} !== x)
		begin
			mismatches++;
			$display("Error status expected %h seen %h", x,
				{stopMode, waitMode, oscRun, deviceReset});
		end
	endtask
	// monitor: every queued note against settled outputs
	always @(posedge core_clk)
	begin
		#1;
		while (expQ.size() > 0)
		begin
			e = expQ.pop_front();
			if (e[8]) cmp_stat(e[3:0]);
			else cmp_reg(e[7:0]);
		end
	end
	task automatic note(input logic [8:0] x);
		expQ.push_back(x);
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge core_clk);
		bus = '{wrEn: 1'b1, addr: dwd_pkg::WATCHDOG_CONTROL_ADDR, wrData: d};
		@(negedge core_clk);
		bus.wrEn = 1'b0;
	endtask
	task automatic strobe(input logic wake);
		@(negedge core_clk);
		if (wake) wakeEvent = 1'b1;
		else stopRequest = 1'b1;
		@(negedge core_clk);
		wakeEvent = 1'b0;
		stopRequest = 1'b0;
	endtask
	initial
	begin
		v = $urandom(20605);
		repeat (4) @(negedge core_clk);
		reset = 1'b0;
		note({1'b0, 8'hFE});
		note(9'h102);
		v = $urandom;
		v[0] = 1'b0;
		wr(v);
		note({1'b0, v});
		wr(8'h00);
		repeat (3) @(negedge core_clk);
		note(9'h102);
		strobe(1'b0);
		note(9'h108);
		strobe(1'b1);
		note(9'h102);
		wr(8'h03);
		wr(8'h02);
		note({1'b0, 8'h03});
		repeat (3060) @(negedge core_clk);
		note(9'h102);
		wr(8'h03);
		repeat (3060) @(negedge core_clk);
		note(9'h102);
		repeat (10) @(negedge core_clk);
		note(9'h102);
		@(negedge core_clk);
		note(9'h103);
		note({1'b0, 8'hFE});
		repeat (63) @(negedge core_clk);
		note(9'h103);
		@(negedge core_clk);
		note(9'h102);
		note({1'b0, 8'hFE});
		wr(8'h03);
		wr(8'h01);
		note(9'h103);
		repeat (70) @(negedge core_clk);
		hwActivation = 1'b1;
		strobe(1'b0);
		note(9'h106);
		strobe(1'b1);
		extStopControl = 1'b1;
		strobe(1'b0);
		note(9'h106);
		strobe(1'b1);
		wr(8'hFE);
		note({1'b0, 8'hFF});
		nmiPin = 1'b1;
		strobe(1'b0);
		note(9'h108);
		repeat (3100) @(negedge core_clk);
		note({1'b0, 8'hFF});
		strobe(1'b1);
		repeat (3068) @(negedge core_clk);
		note({1'b0, 8'hFF});
		@(negedge core_clk);
		note({1'b0, 8'h7F});
		repeat (2) @(negedge core_clk);
		give_verdict();
	end
endmodule
